//--- test/sec_ctrl_bench.sv
/* Self-checking bench for the serial ROM controller.
   Assumes the ROM model on the link and the bound port checker. */
`timescale 1ns/1ps
module sec_ctrl_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic        pull_up = 1'b1;
    logic        present = 1'b1;
    logic [31:0] wait_ns = 32'd200;
    wire  [31:0] rdata;
    wire  [47:0] station;
    wire         irq, cs, sck, pin_o, oe, drv_en, drv_val;
    wire         pin = oe ? pin_o : drv_en ? drv_val : pull_up;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    sec_ctrl #(.HALF_CYC(16), .TIMEOUT_CYC(2000), .TO_W(23)) dut (
        .core_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .irq_o(irq),
        .rom_cs_o(cs), .rom_clk_o(sck), .rom_serial_data_pin_i(pin),
        .rom_serial_data_pin_o(pin_o), .rom_serial_data_pin_oe_o(oe),
        .station_addr_o(station));
    sec_rom_model rom (.cs_i(cs), .sck_i(sck), .pin_i(pin), .present_i(present),
        .wait_ns_i(wait_ns), .drv_en_o(drv_en), .drv_val_o(drv_val));
    // One register cycle; read data is taken in the cycle after the strobe.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        wr_s <= w;
        rd_s <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        @(negedge clk);
        q = rdata;
    endtask
    task automatic chk(input logic [47:0] g, e, input string m);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h", $time, m, g);
        end
    endtask
    // Polls the busy flag with a bounded number of reads.
    task automatic idle(output logic [31:0] c);
        c = 32'h8000_0000;
        for (int i = 0; i < 3000 && c[31] === 1'b1; i++)
            bus(1'b0, 8'hB0, 32'h0, c);
        chk(c[31], 1'b0, "busy stuck");
    endtask
    task automatic cmd(input logic [2:0] op, input logic [7:0] a, output logic [31:0] c);
        bus(1'b1, 8'hB0, {1'b1, op, 20'h0, a}, c);
        idle(c);
    endtask
    task automatic t_power();
        logic [31:0] c;
        bus(1'b0, 8'hB4, 32'h0, c);
        chk(c, 32'h0, "data reset");
        bus(1'b0, 8'hB0, 32'h0, c);
        chk(c[9:0], 10'h0, "cmd reset");
        bus(1'b0, 8'hC0, 32'h0, c);
        chk(c, 32'h0, "unmapped");
        idle(c);
        chk(c[8], 1'b1, "loaded");
        chk(station, {rom.mem[6], rom.mem[5], rom.mem[4], rom.mem[3], rom.mem[2],
            rom.mem[1]}, "station");
        bus(1'b1, 8'hB0, 32'h100, c);
        bus(1'b0, 8'hB0, 32'h0, c);
        chk(c[8], 1'b0, "loaded clear");
        cmd(3'h7, 8'h00, c);
        chk(c[8], 1'b1, "reload");
        $display("t_power done");
    endtask
    task automatic t_write();
        logic [31:0] c;
        cmd(3'h2, 8'h00, c);
        bus(1'b1, 8'hB4, 32'hFFFF_FF5A, c);
        bus(1'b0, 8'hB4, 32'h0, c);
        chk(c, 32'h5A, "data mask");
        bus(1'b1, 8'hB0, 32'hB000_003C, c);
        bus(1'b1, 8'hB0, 32'h8000_0011, c);
        idle(c);
        chk({c[30:28], c[7:0]}, 11'h33C, "busy ignore");
        chk(rom.mem[8'h3C], 8'h5A, "write");
        bus(1'b1, 8'hB4, 32'h0, c);
        cmd(3'h0, 8'h3C, c);
        bus(1'b0, 8'hB4, 32'h0, c);
        chk(c, 32'h5A, "read");
        $display("t_write done");
    endtask
    task automatic t_all();
        logic [31:0] c;
        wait_ns <= 32'd3000;
        bus(1'b1, 8'hB4, 32'h33, c);
        cmd(3'h4, 8'h00, c);
        chk({rom.mem[0], rom.mem[255]}, 16'h3333, "write all");
        cmd(3'h5, 8'h05, c);
        chk(rom.mem[5], 8'hFF, "erase");
        cmd(3'h6, 8'h00, c);
        chk(rom.mem[8'h77], 8'hFF, "erase all");
        chk(c[9], 1'b0, "slow answer");
        cmd(3'h1, 8'h00, c);
        cmd(3'h3, 8'h05, c);
        chk(rom.mem[5], 8'hFF, "locked write");
        wait_ns <= 32'd200;
        $display("t_all done");
    endtask
    task automatic t_tout();
        logic [31:0] c;
        present <= 1'b0;
        pull_up <= 1'b0;
        bus(1'b1, 8'hBC, 32'h2, c);
        cmd(3'h3, 8'h01, c);
        chk({c[9], irq}, 2'b11, "time-out");
        chk(cs, 1'b0, "abandon");
        bus(1'b1, 8'hB8, 32'h3, c);
        cmd(3'h0, 8'h01, c);
        chk({c[9], irq}, 2'b00, "read no time-out");
        pull_up <= 1'b1;
        cmd(3'h6, 8'h00, c);
        chk(c[9], 1'b0, "pulled high");
        bus(1'b0, 8'hB8, 32'h0, c);
        chk(c[1:0], 2'b01, "status");
        present <= 1'b1;
        bus(1'b1, 8'hB0, 32'h100, c);
        cmd(3'h7, 8'h00, c);
        chk(c[8], 1'b0, "bad signature");
        $display("t_tout done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial forever #2.5 clk = ~clk;
    // Loads the ROM image, releases reset and runs the scenarios.
    initial begin
        for (int i = 0; i < 256; i++)
            rom.mem[i] = 8'(i * 7 + 1);
        rom.mem[0] = 8'hA5;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // The internal reset copy needs two edges before registers answer.
        repeat (2) @(posedge clk);
        t_power();
        t_write();
        t_all();
        t_tout();
        close_out();
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        #300000;
        n_mismatch++;
        close_out();
    end
endmodule

//--- test/sec_ctrl_checker.sv
/* Port assertions for the serial ROM controller.
   Assumes a bind into sec_ctrl with its own parameters. */
`timescale 1ns/1ps
module sec_ctrl_checker #(
    parameter HALF_CYC    = 16,
    parameter TIMEOUT_CYC = 2000
) (
    input wire logic        core_clk_i,
    input wire logic        reset_n_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        rom_cs_o,
    input wire logic        rom_clk_o,
    input wire logic        rom_serial_data_pin_o,
    input wire logic        rom_serial_data_pin_oe_o
);
    int hi_cnt;
    int cs_cnt;
    // Measures each high link phase and each select span.
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hi_cnt <= 0;
            cs_cnt <= 0;
        end else begin
            hi_cnt <= rom_clk_o ? hi_cnt + 1 : 0;
            cs_cnt <= rom_cs_o ? cs_cnt + 1 : 0;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence cmd_rd;
        reg_rd_i && reg_addr_i == 8'hB0;
    endsequence
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data not idle");
    cmd_fields_a: assert property (cmd_rd |=> reg_rdata_o[27:10] == 18'h0)
        else $error("command spare bits set");
    data_upper_a: assert property (reg_rd_i && reg_addr_i == 8'hB4 |=>
        reg_rdata_o[31:8] == 24'h0) else $error("data upper bits set");
    clk_idle_a: assert property (!rom_cs_o |-> !rom_clk_o)
        else $error("link clock outside frame");
    half_period_a: assert property ($fell(rom_clk_o) |-> hi_cnt == HALF_CYC)
        else $error("link half period wrong");
    pin_stable_a: assert property (rom_serial_data_pin_oe_o && rom_clk_o &&
        $past(rom_clk_o) |-> $stable(rom_serial_data_pin_o)) else $error("pin moved");
    start_bit_a: assert property ($rose(rom_cs_o) && rom_serial_data_pin_oe_o
        |-> rom_serial_data_pin_o) else $error("start bit low");
    oe_frame_a: assert property (!rom_cs_o |-> !rom_serial_data_pin_oe_o)
        else $error("pin driven while idle");
    cs_bound_a: assert property (rom_cs_o |-> cs_cnt <= TIMEOUT_CYC + 64)
        else $error("select held past time-out");
endmodule
bind sec_ctrl sec_ctrl_checker #(.HALF_CYC(HALF_CYC), .TIMEOUT_CYC(TIMEOUT_CYC)) chk (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rom_cs_o(rom_cs_o),
    .rom_clk_o(rom_clk_o), .rom_serial_data_pin_o(rom_serial_data_pin_o),
    .rom_serial_data_pin_oe_o(rom_serial_data_pin_oe_o));

//--- test/sec_rom_model.sv
/* Behavioural serial ROM on the far side of the link.
   Assumes the bench resolves the pin from all drivers and a pull. */
`timescale 1ns/1ps
module sec_rom_model (
    input  wire logic        cs_i,
    input  wire logic        sck_i,
    input  wire logic        pin_i,
    input  wire logic        present_i,
    input  wire logic [31:0] wait_ns_i,
    output wire logic        drv_en_o,
    output wire logic        drv_val_o
);
    logic [7:0]  mem [0:255];
    logic [18:0] sh = 19'h0;
    logic [1:0]  op = 2'b00;
    logic [7:0]  ad = 8'h00;
    logic        rd = 1'b0;
    logic        dv = 1'b0;
    logic        poll = 1'b0;
    logic        ready = 1'b1;
    logic        unlocked = 1'b0;
    int          n = 0;
    // The pin is driven only for read bits and the ready answer.
    assign drv_en_o = present_i & cs_i & (rd | poll);
    assign drv_val_o = poll ? ready : dv;
    // Shifts host bits in on the rising clock and puts read bits out after it.
    always @(posedge sck_i) begin
        if (cs_i) begin
            n = n + 1;
            sh = {sh[17:0], pin_i};
            if (n == 11) begin
                op = sh[9:8];
                ad = sh[7:0];
            end
            rd = op == 2'b10 && n >= 11 && n < 20;
            dv = n < 12 ? 1'b0 : mem[ad][19 - n];
        end
    end
    // Commits a frame; unlocked erase and write kinds then stay busy for a while.
    always @(negedge cs_i) begin
        rd = 1'b0;
        if (n == 0)
            poll = 1'b0;
        else begin
            poll = op[0] || (op == 2'b00 && (ad[7] ^ ad[6]));
            ready = !(poll && unlocked);
            ready <= #(wait_ns_i) 1'b1;
            if (op == 2'b00 && ad[7] == ad[6])
                unlocked = ad[7];
            for (int i = 0; i < 256; i++)
                if (unlocked && (op == 2'b00 && (ad[7] ^ ad[6]) || i == ad && op[0]))
                    mem[i] = (op[1] || ad[7] && op == 2'b00) ? 8'hFF : sh[7:0];
            n = 0;
        end
    end
endmodule

//--- verilog/sec_ctrl.v
/*
 * Serial ROM controller: host command and data registers, a three-wire
 * serial link sequencer with one two-way data pin, station address
 * reload at power-up, busy time-out and a masked interrupt.
 * Assumes the ROM samples data on the rising link clock and drives
 * read data after it; the pin is pulled to a defined level externally.
 */
// Added by the designer: the strobed register port.
// Operation
// - A started operation that sees no ready answer for 30 ms is abandoned and goes idle.
// - A time-out sets the time-out flag at command bit 9, which resets to zero.
// - With the data pin held high and no ROM, commands end without time-out and busy clears.
// - With the pin low and no ROM only erase, erase-all, write and write-all can time out.
// - The address-loaded flag at bit 8 is set after a good station address load.
// - The host reads the address-loaded flag and clears it by writing a one.
// - Command bits 7-0 hold the ROM byte address and reset to 00h.
// - Data bits 7:0 hold the last read or host byte, reset 00h, bits 31-8 read zero.
// - Write-all sends the data byte to be stored in every ROM location.
`timescale 1ns/1ps
`include "sec_map.vh"

module sec_ctrl #(
    parameter HALF_CYC    = `SEC_HALF_CYC,
    parameter TIMEOUT_CYC = `SEC_TIMEOUT_MS * `SEC_CLK_KHZ,
    parameter TO_W        = 23
) (
    input  wire        core_clk_i,
    input  wire        reset_n_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    output wire        irq_o,
    output reg         rom_cs_o,
    output reg         rom_clk_o,
    input  wire        rom_serial_data_pin_i,
    output wire        rom_serial_data_pin_o,
    output wire        rom_serial_data_pin_oe_o,
    output reg  [47:0] station_addr_o
);

    localparam ST_IDLE  = 4'b0001;
    localparam ST_SHIFT = 4'b0010;
    localparam ST_GAP   = 4'b0100;
    localparam ST_POLL  = 4'b1000;

    // Start bit, two opcode bits and eight address bits for a command.
    function [10:0] sec_hdr;
        input [2:0] op;
        input [7:0] a;
        begin
            case (op)
                `SEC_OP_READ:   sec_hdr = {3'b110, a};
                `SEC_OP_WRITE:  sec_hdr = {3'b101, a};
                `SEC_OP_ERASE:  sec_hdr = {3'b111, a};
                `SEC_OP_UNLOCK: sec_hdr = {3'b100, 8'hC0};
                `SEC_OP_WRALL:  sec_hdr = {3'b100, 8'h40};
                `SEC_OP_ERALL:  sec_hdr = {3'b100, 8'h80};
                default:        sec_hdr = {3'b100, 8'h00};
            endcase
        end
    endfunction

    // Commands that carry or return a data byte.
    function sec_has_byte;
        input [2:0] op;
        begin
            sec_has_byte = (op == `SEC_OP_READ) || (op == `SEC_OP_WRITE) ||
                           (op == `SEC_OP_WRALL);
        end
    endfunction

    // Commands that end with a ready poll and so may time out.
    function sec_polls;
        input [2:0] op;
        begin
            sec_polls = (op == `SEC_OP_WRITE) || (op == `SEC_OP_WRALL) ||
                        (op == `SEC_OP_ERASE) || (op == `SEC_OP_ERALL);
        end
    endfunction

    reg              rst_q1;
    reg              rst_q2;
    reg              din_q1;
    reg              din_q2;
    reg              busy;
    reg  [2:0]       cmd;
    reg              tout_flag;
    reg              loaded_flag;
    reg  [7:0]       rom_addr;
    reg  [7:0]       rom_data;
    reg  [1:0]       irq_stat;
    reg  [1:0]       irq_mask;
    reg  [3:0]       state;
    reg  [7:0]       div_cnt;
    reg  [4:0]       bit_cnt;
    reg  [18:0]      tx;
    reg  [7:0]       rx;
    reg  [TO_W-1:0]  to_cnt;
    reg              reloading;
    reg              reload_pend;
    reg  [2:0]       rl_idx;
    reg  [1:0]       ev_set;

    wire       rst_n   = rst_q2;
    wire       tick    = (div_cnt == HALF_CYC[7:0] - 8'h01);
    wire       wr_cmd  = reg_wr_i && (reg_addr_i == `SEC_CMD_OFS);
    wire       wr_data = reg_wr_i && (reg_addr_i == `SEC_DATA_OFS);
    wire [2:0] w_op    = reg_wdata_i[`SEC_CMD_OP_HI:`SEC_CMD_OP_LO];
    wire       host_go = wr_cmd && !busy && reg_wdata_i[`SEC_CMD_BUSY];
    wire       rl_go   = reload_pend || (host_go && (w_op == `SEC_OP_RELOAD));
    wire [2:0] l_op    = rl_go ? `SEC_OP_READ : w_op;
    wire [7:0] l_addr  = rl_go ? 8'h00 : reg_wdata_i[7:0];
    wire [7:0] l_byte  = wr_data ? reg_wdata_i[7:0] : rom_data;

    // Data pin is released while the ROM drives read data or ready.
    assign rom_serial_data_pin_o    = tx[18];
    assign rom_serial_data_pin_oe_o = (state == ST_SHIFT) &&
                                      !(cmd == `SEC_OP_READ && bit_cnt <= 5'd8);
    assign irq_o = |(irq_stat & irq_mask);

    // Reset release through two flip-flops.
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end

    // Two-stage synchroniser for the returned data pin.
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            din_q1 <= 1'b0;
            din_q2 <= 1'b0;
        end else begin
            din_q1 <= rom_serial_data_pin_i;
            din_q2 <= din_q1;
        end
    end

    // Link clock divider runs whenever the sequencer is not idle.
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 8'h00;
        end else if (state == ST_IDLE || tick) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // Sequencer, command and data registers.
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            busy           <= 1'b1;
            cmd            <= `SEC_OP_RELOAD;
            tout_flag      <= 1'b0;
            loaded_flag    <= 1'b0;
            rom_addr       <= `SEC_ADDR_RST;
            rom_data       <= `SEC_DATA_RST;
            state          <= ST_IDLE;
            bit_cnt        <= 5'd0;
            tx             <= 19'h0;
            rx             <= 8'h00;
            to_cnt         <= {TO_W{1'b0}};
            reloading      <= 1'b0;
            reload_pend    <= 1'b1;
            rl_idx         <= 3'h0;
            rom_cs_o       <= 1'b0;
            rom_clk_o      <= 1'b0;
            station_addr_o <= 48'h000000000000;
            ev_set         <= 2'b00;
        end else begin
            ev_set <= 2'b00;
            if (wr_cmd && !busy) begin
                rom_addr <= reg_wdata_i[7:0];
            end
            if (wr_data && !busy) begin
                rom_data <= reg_wdata_i[7:0];
            end
            if (wr_cmd && reg_wdata_i[`SEC_CMD_LOADED]) begin
                loaded_flag <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    rom_cs_o  <= 1'b0;
                    rom_clk_o <= 1'b0;
                    if (rl_go || host_go) begin
                        busy        <= 1'b1;
                        cmd         <= l_op;
                        tout_flag   <= 1'b0;
                        reloading   <= rl_go;
                        reload_pend <= 1'b0;
                        rl_idx      <= 3'h0;
                        tx          <= {sec_hdr(l_op, l_addr), l_byte};
                        bit_cnt     <= sec_has_byte(l_op) ? 5'd19 : 5'd11;
                        rom_cs_o    <= 1'b1;
                        state       <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (tick) begin
                        rom_clk_o <= ~rom_clk_o;
                        // Falling edge: sample the ROM and present the next bit.
                        if (rom_clk_o) begin
                            rx      <= {rx[6:0], din_q2};
                            tx      <= {tx[17:0], 1'b0};
                            bit_cnt <= bit_cnt - 5'd1;
                            if (bit_cnt == 5'd1) begin
                                rom_cs_o <= 1'b0;
                                state    <= ST_GAP;
                            end
                        end
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        if (sec_polls(cmd)) begin
                            rom_cs_o <= 1'b1;
                            to_cnt   <= {TO_W{1'b0}};
                            state    <= ST_POLL;
                        end else if (reloading) begin
                            if (rl_idx == 3'h0 && rx != `SEC_SIGNATURE) begin
                                busy      <= 1'b0;
                                reloading <= 1'b0;
                                ev_set    <= 2'b01;
                                state     <= ST_IDLE;
                            end else if (rl_idx == `SEC_STATION_LAST) begin
                                station_addr_o <= {rx, station_addr_o[47:8]};
                                loaded_flag    <= 1'b1;
                                busy           <= 1'b0;
                                reloading      <= 1'b0;
                                ev_set         <= 2'b01;
                                state          <= ST_IDLE;
                            end else begin
                                if (rl_idx != 3'h0) begin
                                    station_addr_o <= {rx, station_addr_o[47:8]};
                                end
                                rl_idx   <= rl_idx + 3'h1;
                                tx       <= {sec_hdr(`SEC_OP_READ,
                                                     {5'h00, rl_idx + 3'h1}), 8'h00};
                                bit_cnt  <= 5'd19;
                                rom_cs_o <= 1'b1;
                                state    <= ST_SHIFT;
                            end
                        end else begin
                            // Read byte lands in the same cycle as busy clears.
                            if (cmd == `SEC_OP_READ) begin
                                rom_data <= rx;
                            end
                            busy   <= 1'b0;
                            ev_set <= 2'b01;
                            state  <= ST_IDLE;
                        end
                    end
                end
                ST_POLL: begin
                    to_cnt <= to_cnt + {{(TO_W-1){1'b0}}, 1'b1};
                    // Ready only after the synchroniser has seen chip select.
                    if (din_q2 && to_cnt[TO_W-1:2] != {(TO_W-2){1'b0}}) begin
                        busy     <= 1'b0;
                        rom_cs_o <= 1'b0;
                        ev_set   <= 2'b01;
                        state    <= ST_IDLE;
                    end else if (to_cnt == TIMEOUT_CYC[TO_W-1:0] - 1'b1) begin
                        busy      <= 1'b0;
                        rom_cs_o  <= 1'b0;
                        tout_flag <= 1'b1;
                        ev_set    <= 2'b11;
                        state     <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Interrupt status and mask; a new event wins over a clear.
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= 2'b00;
            irq_mask <= 2'b00;
        end else begin
            if (reg_wr_i && reg_addr_i == `SEC_IMASK_OFS) begin
                irq_mask <= reg_wdata_i[1:0];
            end
            if (reg_wr_i && reg_addr_i == `SEC_ISTAT_OFS) begin
                irq_stat <= (irq_stat & ~reg_wdata_i[1:0]) | ev_set;
            end else begin
                irq_stat <= irq_stat | ev_set;
            end
        end
    end

    // Read data, one cycle after the read strobe; unmapped reads zero.
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `SEC_CMD_OFS:   reg_rdata_o <= {busy, cmd, 18'h0, tout_flag,
                                                loaded_flag, rom_addr};
                `SEC_DATA_OFS:  reg_rdata_o <= {24'h000000, rom_data};
                `SEC_ISTAT_OFS: reg_rdata_o <= {30'h0, irq_stat};
                `SEC_IMASK_OFS: reg_rdata_o <= {30'h0, irq_mask};
                default:        reg_rdata_o <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_o <= 32'h00000000;
        end
    end

endmodule

//--- verilog/sec_map.vh
/*
 * Register offsets, field positions, command codes and timing figures
 * for the serial ROM controller.
 * Assumes a 200 MHz core clock and an 8-bit byte address register port.
 */
`ifndef SEC_MAP_VH
`define SEC_MAP_VH

// Register byte offsets.
`define SEC_CMD_OFS      8'hB0
`define SEC_DATA_OFS     8'hB4
`define SEC_ISTAT_OFS    8'hB8
`define SEC_IMASK_OFS    8'hBC

// Command register fields.
`define SEC_CMD_BUSY     31
`define SEC_CMD_OP_HI    30
`define SEC_CMD_OP_LO    28
`define SEC_CMD_TOUT     9
`define SEC_CMD_LOADED   8
`define SEC_ADDR_RST     8'h00
`define SEC_DATA_RST     8'h00

// Interrupt status bits.
`define SEC_IRQ_DONE     0
`define SEC_IRQ_TOUT     1

// Host command codes.
`define SEC_OP_READ      3'h0
`define SEC_OP_LOCK      3'h1
`define SEC_OP_UNLOCK    3'h2
`define SEC_OP_WRITE     3'h3
`define SEC_OP_WRALL     3'h4
`define SEC_OP_ERASE     3'h5
`define SEC_OP_ERALL     3'h6
`define SEC_OP_RELOAD    3'h7

// Signature byte expected at ROM location zero.
`define SEC_SIGNATURE    8'hA5
`define SEC_STATION_LAST 3'h6

// Timing: core clock in kHz, time-out in ms, link half period in cycles.
`define SEC_CLK_KHZ      200000
`define SEC_TIMEOUT_MS   30
`define SEC_HALF_CYC     64

`endif
